// ===== logic/rrb_pkg.sv
// Package for the type B remote receive capture block
package rrb_pkg;
	localparam int RRB_DATA_W = 8;
	localparam int RRB_CNT_W = 4;
	localparam logic [7:0] RRB_SHIFT_RST = 8'h00;
	localparam logic [7:0] RRB_DATA_RST = 8'h00;
	localparam logic [3:0] RRB_CNT_RST = 4'h0;
	localparam logic [3:0] RRB_CNT_FULL = 4'h8;
	localparam logic [1:0] RRB_SYNC_RST = 2'h0;
	typedef enum logic [2:0] {
		RRB_IDLE = 3'b001,
		RRB_RUN = 3'b010,
		RRB_HOLD = 3'b100
	} rrb_state_type;
endpackage

// ===== logic/rrb_buf.sv
// Two-entry buffer between decoded bit source and capture logic
`timescale 1ns/100ps
module rrb_buf (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	input wire logic in_data,
	output logic in_ready,
	output logic out_valid,
	output logic out_data,
	input wire logic out_ready
);
	import rrb_pkg::*;

	typedef struct packed {
		logic [1:0] vld;
		logic [1:0] dat;
	} rrb_buf_type;

	rrb_buf_type s_r;
	rrb_buf_type s_nxt;

	assign in_ready = ~s_r.vld[1];
	assign out_valid = s_r.vld[0];
	assign out_data = s_r.dat[0];

	always_comb begin
		s_nxt = s_r;
		// Pop first so a simultaneous push lands in the freed slot
		if (s_r.vld[0] && out_ready) begin
			s_nxt.vld = {1'b0, s_r.vld[1]};
			s_nxt.dat = {1'b0, s_r.dat[1]};
		end
		if (in_valid && ~s_r.vld[1]) begin
			if (~s_nxt.vld[0]) begin
				s_nxt.vld[0] = 1'b1;
				s_nxt.dat[0] = in_data;
			end else begin
				s_nxt.vld[1] = 1'b1;
				s_nxt.dat[1] = in_data;
			end
		end
		if (flush) begin
			s_nxt.vld = RRB_SYNC_RST;
			s_nxt.dat = RRB_SYNC_RST;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// ===== logic/rrb_capture.sv
// Type B receive capture: shift register, bit counter, data register
`timescale 1ns/100ps
module rrb_capture (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic receiver_enable,
	input wire logic bit_valid,
	input wire logic bit_value,
	output logic bit_ready,
	input wire logic rx_error_event,
	input wire logic rx_end_event,
	input wire logic shift_read,
	output logic [rrb_pkg::RRB_DATA_W-1:0] rx_shift_reg,
	output logic [rrb_pkg::RRB_CNT_W-1:0] rx_bit_counter,
	output logic [rrb_pkg::RRB_DATA_W-1:0] rx_data_reg,
	output logic data_full_event,
	output logic rx_busy,
	output logic rx_held
);
	import rrb_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		rrb_state_type st;
		logic [RRB_DATA_W-1:0] shift;
		logic [RRB_CNT_W-1:0] cnt;
		logic [RRB_DATA_W-1:0] data;
		logic full;
	} rrb_cap_type;

	rrb_cap_type s_r;
	rrb_cap_type s_nxt;
	logic buf_valid;
	logic buf_data;
	logic take;
	logic flush;
	logic [RRB_DATA_W-1:0] shift_in;
	logic [RRB_CNT_W-1:0] cnt_inc;
	logic fill_done;
	logic clr_err;
	logic clr_read;
	logic end_seen;
	logic run_st;
	logic hold_st;

	// ****************************************
	// Input buffer
	// ****************************************
	// Bits wait in the buffer while held, so none is lost on a stall
	assign flush = ~receiver_enable;
	assign take = buf_valid && (s_r.st == RRB_RUN) && ~rx_error_event;

	rrb_buf u_buf (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.flush(flush),
		.in_valid(bit_valid),
		.in_data(bit_value),
		.in_ready(bit_ready),
		.out_valid(buf_valid),
		.out_data(buf_data),
		.out_ready(take)
	);

	assign rx_shift_reg = s_r.shift;
	assign rx_bit_counter = s_r.cnt;
	assign rx_data_reg = s_r.data;
	assign data_full_event = s_r.full;
	assign rx_busy = run_st;
	assign rx_held = hold_st;

	// ****************************************
	// State decode
	// ****************************************
	// Decoded for the outputs; the buffer pop in take compares s_r.st with RRB_RUN itself
	assign run_st = s_r.st == RRB_RUN;
	assign hold_st = s_r.st == RRB_HOLD;

	// ****************************************
	// Shift path
	// ****************************************
	// New bit enters at the top, so the first bit ends in bit 0
	genvar gi;
	generate
		for (gi = 0; gi < RRB_DATA_W; gi++) begin : g_shift
			if (gi == RRB_DATA_W - 1) begin : g_top
				assign shift_in[gi] = buf_data;
			end else begin : g_low
				assign shift_in[gi] = s_r.shift[gi + 1];
			end
		end
	endgenerate

	// ****************************************
	// Counter and events
	// ****************************************
	// Counter never passes the full count, so four bits cannot wrap
	assign cnt_inc = s_r.cnt + 4'h1;
	assign fill_done = take && (cnt_inc == RRB_CNT_FULL);
	// Error outranks a pop; the bit it blocks stays buffered
	assign clr_err = rx_error_event;
	// A read clears in any active state, not only while held
	assign clr_read = shift_read;
	// End in the same cycle as a pop: the pop counts, then hold
	assign end_seen = rx_end_event && ~rx_error_event;

	// ****************************************
	// Capture logic
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.full = 1'b0;
		case (s_r.st)
			RRB_IDLE: begin
				if (receiver_enable) begin
					s_nxt.st = RRB_RUN;
				end
			end
			RRB_RUN: begin
				if (clr_err) begin
					s_nxt.shift = RRB_SHIFT_RST;
					s_nxt.cnt = RRB_CNT_RST;
				end else begin
					if (take) begin
						s_nxt.shift = shift_in;
						s_nxt.cnt = cnt_inc;
					end
					if (fill_done) begin
						// Overwrites an unread byte by design
						s_nxt.data = shift_in;
						s_nxt.full = 1'b1;
						s_nxt.shift = RRB_SHIFT_RST;
						s_nxt.cnt = RRB_CNT_RST;
					end
					if (end_seen) begin
						s_nxt.st = RRB_HOLD;
					end
				end
				if (clr_read) begin
					s_nxt.shift = RRB_SHIFT_RST;
					s_nxt.cnt = RRB_CNT_RST;
				end
			end
			RRB_HOLD: begin
				// Counter must be sampled before this read clears it
				if (clr_read) begin
					s_nxt.shift = RRB_SHIFT_RST;
					s_nxt.cnt = RRB_CNT_RST;
					s_nxt.st = RRB_RUN;
				end else if (clr_err) begin
					s_nxt.shift = RRB_SHIFT_RST;
					s_nxt.cnt = RRB_CNT_RST;
				end
			end
			default: begin
				s_nxt.st = RRB_IDLE;
			end
		endcase
		// ****************************************
		// Stop
		// ****************************************
		// Disable overrides every state, data register included
		if (!receiver_enable) begin
			s_nxt.st = RRB_IDLE;
			s_nxt.shift = RRB_SHIFT_RST;
			s_nxt.cnt = RRB_CNT_RST;
			s_nxt.data = RRB_DATA_RST;
			s_nxt.full = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r.st <= RRB_IDLE;
			s_r.shift <= RRB_SHIFT_RST;
			s_r.cnt <= RRB_CNT_RST;
			s_r.data <= RRB_DATA_RST;
			s_r.full <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// ===== verification/rrb_chk.sv
// Assertion checker for the type B receive capture block
`timescale 1ns/100ps
module rrb_chk (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic receiver_enable,
	input wire logic rx_error_event,
	input wire logic shift_read,
	input wire logic [7:0] rx_shift_reg,
	input wire logic [3:0] rx_bit_counter,
	input wire logic [7:0] rx_data_reg,
	input wire logic data_full_event,
	input wire logic rx_busy,
	input wire logic rx_held
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	err_clear_a: assert property (rx_error_event |=>
		~|{rx_shift_reg, rx_bit_counter}) else $error("error clear");
	full_clear_a: assert property (data_full_event |->
		~|{rx_shift_reg, rx_bit_counter}) else $error("full clear");
	read_clear_a: assert property (shift_read && rx_held |=>
		~|{rx_shift_reg, rx_bit_counter}) else $error("read clear");
	hold_stall_a: assert property (rx_held && receiver_enable &&
		!shift_read && !rx_error_event |=> $stable(rx_bit_counter))
		else $error("hold stall");
	stop_clear_a: assert property (!receiver_enable |=>
		!rx_busy && ~|{rx_shift_reg, rx_bit_counter, rx_data_reg})
		else $error("stop clear");
	cnt_range_a: assert property (rx_bit_counter <= 4'h7)
		else $error("count range");
	cover property (data_full_event);
	cover property (rx_held && shift_read);
	cover property (rx_error_event && rx_bit_counter != 4'h0);
endmodule
bind rrb_capture rrb_chk u_chk (.*);

// ===== verification/rrb_src.sv
// Model of the decoded bit source feeding the capture block
`timescale 1ns/100ps
module rrb_src (
	input wire logic sys_clk,
	input wire logic bit_ready,
	output logic bit_valid,
	output logic bit_value
);
	initial {bit_valid, bit_value} = 2'b00;
	// Slow mode drops valid between bits; idle data is inverted, not held
	task automatic send(input logic [7:0] d, input int n, input bit slow);
		for (int i = 0; i < n; i++) begin
			bit_valid <= 1'b1;
			bit_value <= d[i];
			@(negedge sys_clk);
			while (!bit_ready) @(negedge sys_clk);
			@(posedge sys_clk);
			if (slow) begin
				bit_valid <= 1'b0;
				bit_value <= ~d[i];
				@(posedge sys_clk);
			end
		end
		bit_valid <= 1'b0;
		bit_value <= ~bit_value;
	endtask
endmodule

// ===== verification/remote_rx_type_b_capture_test.sv
// Self-checking testbench for the type B receive capture block
`timescale 1ns/100ps
module remote_rx_type_b_capture_test;
	logic sys_clk = 1'b0, rst_n = 1'b0, receiver_enable = 1'b1;
	logic rx_error_event = 1'b0, rx_end_event = 1'b0, shift_read = 1'b0;
	logic bit_valid, bit_value, bit_ready, data_full_event, rx_busy, rx_held;
	logic [7:0] rx_shift_reg, rx_data_reg, b;
	logic [3:0] rx_bit_counter;
	int errors = 0, num_checks = 0, fulls = 0, exp_fulls = 0;
	always @(posedge sys_clk) if (data_full_event === 1'b1) fulls++;
	// Model of the shift path: LSB first, new bit at the top
	function automatic logic [7:0] sh(input logic [7:0] d, input int n);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < n; i++) s = {d[i], s[7:1]};
		return s;
	endfunction
	rrb_capture DUT (.sys_clk, .rst_n, .receiver_enable, .bit_valid,
		.bit_value, .bit_ready, .rx_error_event, .rx_end_event, .shift_read,
		.rx_shift_reg, .rx_bit_counter, .rx_data_reg, .data_full_event,
		.rx_busy, .rx_held);
	rrb_src SRC (.sys_clk, .bit_ready, .bit_valid, .bit_value);
	initial forever #5 sys_clk = ~sys_clk;
	initial begin
		repeat (4000) @(posedge sys_clk);
		errors++;
		test_done();
	end
	task test_done();
		if (errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Zero count implies an empty shift register in the model
	task settle(input logic [3:0] c, input logic [7:0] d,
			input logic [7:0] s, input logic h);
		repeat (6) @(negedge sys_clk);
		num_checks++;
		if (rx_bit_counter !== c || rx_data_reg !== d ||
				rx_shift_reg !== s) begin
			errors++;
			$display("FAIL %0t count %h data %h", $time,
				rx_bit_counter, rx_data_reg);
		end
		if (fulls !== exp_fulls || rx_held !== h ||
				rx_busy !== (receiver_enable && !h)) begin
			errors++;
			$display("FAIL %0t full count or state", $time);
		end
		@(posedge sys_clk);
	endtask
	initial begin
		void'($urandom(23));
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			b = 8'($urandom);
			SRC.send(b, 8, k[0]);
			exp_fulls++;
			settle(4'h0, b, 8'h00, 1'b0);
		end
		SRC.send(8'h05, 3, 1'b0);
		settle(4'h3, b, sh(8'h05, 3), 1'b0);
		rx_end_event <= 1'b1;
		@(posedge sys_clk);
		rx_end_event <= 1'b0;
		SRC.send(8'h02, 2, 1'b1);
		settle(4'h3, b, sh(8'h05, 3), 1'b1);
		shift_read <= 1'b1;
		@(posedge sys_clk);
		shift_read <= 1'b0;
		settle(4'h2, b, sh(8'h02, 2), 1'b0);
		rx_error_event <= 1'b1;
		@(posedge sys_clk);
		rx_error_event <= 1'b0;
		settle(4'h0, b, 8'h00, 1'b0);
		receiver_enable <= 1'b0;
		settle(4'h0, 8'h00, 8'h00, 1'b0);
		test_done();
	end
endmodule
